// >>> hdl/spa_map.svh
// Constants of the serial alignment controller
`ifndef SPA_MAP_SVH
`define SPA_MAP_SVH
`define SPA_WORD_W      10
`define SPA_CNT_LAST    4'h9
`define SPA_K285_NEG    10'h17C
`define SPA_K285_POS    10'h283
`define SPA_RUN_MAX     4'h5
`define SPA_RUN_SAT     4'hF
`define SPA_COMMA_WIN   8'hFF
`define SPA_RATIO_10    2'h0
`define SPA_RATIO_20    2'h1
`define SPA_RATIO_40    2'h2
`define SPA_SER_IDLE    2'h2
`endif

// >>> hdl/spa_pkg.sv
// Types of the serial alignment controller
package spa_pkg;
	typedef struct packed {
		logic p;
		logic n;
	} spa_pair_t;
endpackage

// >>> hdl/spa_align_ctrl.sv
// Serializer, deserializer, comma alignment and signal-loss logic
`timescale 1ns/100ps
`default_nettype none
`include "spa_map.svh"
module spa_align_ctrl #(
	parameter bit ALT_PINOUT = 1'b0
) (
	input  wire logic              clk_sys,
	input  wire logic              rst,
	input  wire logic              ce,
	input  wire logic              tx_byte_clk,
	input  wire logic [9:0]        tx_data,
	input  wire logic              tx_speed_sel,
	input  wire logic              ref_clk_a,
	input  wire logic [1:0]        ref_ratio_sel,
	input  wire logic              loopback_en,
	input  wire spa_pkg::spa_pair_t rx_in,
	input  wire logic              rx_speed_sel,
	input  wire logic              align_en,
	output var  spa_pkg::spa_pair_t ser_out,
	output var  logic [9:0]        rx_word,
	output var  logic              rec_clk_a,
	output var  logic              rec_clk_b,
	output var  logic              comma_found,
	output var  logic              rx_signal_lost
);
	logic [9:0] tx_hold_r;
	logic [9:0] tx_sh_r;
	logic [3:0] tx_cnt_r;
	logic       tx_bit_r;
	logic       tx_clk_q_r;
	logic       tx_ph_r;
	logic       rx_ph_r;
	logic [9:0] rx_sh_r;
	logic [9:0] rx_sh_nxt;
	logic [3:0] rx_cnt_r;
	logic       rx_last_r;
	logic [3:0] run_cnt_r;
	logic [7:0] comma_age_r;
	logic       ref_q_r;
	logic [1:0] ratio;
	logic       tx_tick;
	logic       rx_tick;
	logic       rx_bit;
	logic       match;
	logic       word_evt;
	logic       ref_tick;

	// Half speed simply skips every other cycle
	assign tx_tick = ce && (tx_speed_sel || tx_ph_r);
	assign rx_tick = ce && (rx_speed_sel || rx_ph_r);
	// Equal legs read as zero, which also trips the run checker
	assign rx_bit = loopback_en ? tx_bit_r : (rx_in.p & ~rx_in.n);
	assign rx_sh_nxt = {rx_bit, rx_sh_r[9:1]};
	assign match = (rx_sh_nxt == `SPA_K285_NEG) ||
		(rx_sh_nxt == `SPA_K285_POS);
	assign word_evt = rx_tick && ((rx_cnt_r == `SPA_CNT_LAST) ||
		(align_en && match));
	assign ratio = ALT_PINOUT ? `SPA_RATIO_10 : ref_ratio_sel;
	// A faster word rate per reference period uses both reference edges
	assign ref_tick = ce && ((ratio == `SPA_RATIO_10) ?
		(ref_clk_a && !ref_q_r) : (ref_clk_a != ref_q_r));

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tx_ph_r <= 1'b0;
			rx_ph_r <= 1'b0;
			tx_clk_q_r <= 1'b0;
			ref_q_r <= 1'b0;
		end else if (ce) begin
			tx_ph_r <= ~tx_ph_r;
			rx_ph_r <= ~rx_ph_r;
			tx_clk_q_r <= tx_byte_clk;
			ref_q_r <= ref_clk_a;
		end
	end

	// Partner keeps tx_byte_clk locked to the reference, so no word slips while tx_speed_sel is high
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tx_hold_r <= 10'h000;
		end else if (ce && tx_byte_clk && !tx_clk_q_r) begin
			tx_hold_r <= tx_data;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tx_sh_r <= 10'h000;
			tx_cnt_r <= 4'h0;
			tx_bit_r <= 1'b0;
		end else if (tx_tick) begin
			tx_bit_r <= tx_sh_r[0];
			if (tx_cnt_r == `SPA_CNT_LAST) begin
				tx_sh_r <= tx_hold_r;
				tx_cnt_r <= 4'h0;
			end else begin
				tx_sh_r <= {1'b0, tx_sh_r[9:1]};
				tx_cnt_r <= tx_cnt_r + 4'h1;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ser_out <= `SPA_SER_IDLE;
		end else if (ce) begin
			if (loopback_en) begin
				ser_out <= `SPA_SER_IDLE;
			end else begin
				ser_out <= {tx_bit_r, ~tx_bit_r};
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rx_sh_r <= 10'h000;
			rx_cnt_r <= 4'h0;
			rx_word <= 10'h000;
		end else if (rx_tick) begin
			rx_sh_r <= rx_sh_nxt;
			if (word_evt) begin
				rx_word <= rx_sh_nxt;
				rx_cnt_r <= 4'h0;
			end else begin
				rx_cnt_r <= rx_cnt_r + 4'h1;
			end
		end
	end

	// A comma forces rec_clk_b high so the comma word lands on its rise;
	// a comma that arrives while rec_clk_b is already high goes unflagged
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rec_clk_a <= 1'b1;
			rec_clk_b <= 1'b0;
			comma_found <= 1'b0;
		end else if (ce) begin
			if (!align_en) begin
				comma_found <= 1'b0;
			end else if (word_evt) begin
				comma_found <= match && !rec_clk_b;
			end
			if (word_evt && align_en && match) begin
				rec_clk_a <= 1'b0;
				rec_clk_b <= 1'b1;
			end else if (rx_signal_lost ? ref_tick : word_evt) begin
				rec_clk_a <= ~rec_clk_a;
				rec_clk_b <= rec_clk_a;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rx_last_r <= 1'b0;
			run_cnt_r <= `SPA_RUN_SAT;
			comma_age_r <= `SPA_COMMA_WIN;
		end else if (rx_tick) begin
			rx_last_r <= rx_bit;
			if (rx_bit != rx_last_r) begin
				run_cnt_r <= 4'h1;
			end else if (run_cnt_r != `SPA_RUN_SAT) begin
				run_cnt_r <= run_cnt_r + 4'h1;
			end
			if (match) begin
				comma_age_r <= 8'h00;
			end else if (rx_cnt_r == `SPA_CNT_LAST &&
				comma_age_r != `SPA_COMMA_WIN) begin
				comma_age_r <= comma_age_r + 8'h01;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			rx_signal_lost <= 1'b1;
		end else if (ce) begin
			rx_signal_lost <= (run_cnt_r > `SPA_RUN_MAX) ||
				(comma_age_r == `SPA_COMMA_WIN);
		end
	end

	property p_capture;
		@(posedge clk_sys) disable iff (rst)
		ce && tx_byte_clk && !tx_clk_q_r |=> tx_hold_r == $past(tx_data);
	endproperty
	a_capture: assert property (p_capture)
		else $error("transmit word not captured");

	property p_bit_order;
		@(posedge clk_sys) disable iff (rst)
		tx_tick |=> tx_bit_r == $past(tx_sh_r[0]);
	endproperty
	a_bit_order: assert property (p_bit_order)
		else $error("serial bit not taken from bit 0");

	property p_tx_half;
		@(posedge clk_sys) disable iff (rst)
		tx_tick && !tx_speed_sel ##1 !tx_speed_sel |-> !tx_tick;
	endproperty
	a_tx_half: assert property (p_tx_half)
		else $error("half speed sent two bits in a row");

	property p_wrap_idle;
		@(posedge clk_sys) disable iff (rst)
		ce && loopback_en |=> ser_out.p && !ser_out.n;
	endproperty
	a_wrap_idle: assert property (p_wrap_idle)
		else $error("serial output not idle in loopback");

	property p_wrap_feed;
		@(posedge clk_sys) disable iff (rst)
		rx_tick && loopback_en |=> rx_sh_r[9] == $past(tx_bit_r);
	endproperty
	a_wrap_feed: assert property (p_wrap_feed)
		else $error("loopback did not feed receiver");

	property p_clk_pair;
		@(posedge clk_sys) disable iff (rst)
		rec_clk_a != rec_clk_b;
	endproperty
	a_clk_pair: assert property (p_clk_pair)
		else $error("recovered clocks not complementary");

	property p_comma_word;
		@(posedge clk_sys) disable iff (rst)
		comma_found |-> rx_word == `SPA_K285_NEG || rx_word == `SPA_K285_POS;
	endproperty
	a_comma_word: assert property (p_comma_word)
		else $error("comma flag without comma word");

	property p_comma_rise;
		@(posedge clk_sys) disable iff (rst)
		$rose(comma_found) |-> $rose(rec_clk_b);
	endproperty
	a_comma_rise: assert property (p_comma_rise)
		else $error("comma flag not on rec_clk_b rise");

	property p_comma_off;
		@(posedge clk_sys) disable iff (rst)
		ce && !align_en |=> !comma_found;
	endproperty
	a_comma_off: assert property (p_comma_off)
		else $error("comma flag while alignment off");

	property p_los_run;
		@(posedge clk_sys) disable iff (rst)
		ce && run_cnt_r > `SPA_RUN_MAX |=> rx_signal_lost;
	endproperty
	a_los_run: assert property (p_los_run)
		else $error("long run not reported as loss");
endmodule
`default_nettype wire

// >>> bench/spa_proto_model.sv
// Parallel-side partner model: byte clock, reference clock and words
`timescale 1ns/100ps
`default_nettype none
module spa_proto_model #(
	parameter logic [9:0] FILL = 10'h2AA
) (
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic [9:0] word,
	output var  logic       tx_byte_clk,
	output var  logic       ref_clk_a,
	output var  logic [9:0] tx_data
);
	logic [3:0] ph_r;
	logic       odd_r;
	// One shared divider, so byte clock and reference never drift
	assign tx_byte_clk = (ph_r < 4'h5);
	assign ref_clk_a = (ph_r < 4'h5);
	// Filler between commas lets the second recovered clock rise again
	always @(negedge clk_sys or posedge rst) begin
		if (rst) begin
			ph_r <= 4'h0;
			odd_r <= 1'b0;
			tx_data <= FILL;
		end else begin
			ph_r <= (ph_r == 4'h9) ? 4'h0 : ph_r + 4'h1;
			if (ph_r == 4'h7) begin
				odd_r <= ~odd_r;
				tx_data <= odd_r ? FILL : word;
			end
		end
	end
endmodule
`default_nettype wire

// >>> bench/serdes_parallel_align_ctrl_bench.sv
// Self-checking bench of the serial alignment controller
`timescale 1ns/100ps
`default_nettype none
`include "spa_map.svh"
`define SPA_CHK(g, e) begin n_compared++; if ((g) !== (e)) begin \
	miscompares++; \
	$display("[ERR] t=%0t got=%0h exp=%0h", $time, g, e); end end
module serdes_parallel_align_ctrl_bench;
	logic               clk_sys, rst, loopback_en, align_en;
	logic               tx_byte_clk, ref_clk_a, rec_clk_a, rec_clk_b;
	logic               comma_found, rx_signal_lost;
	logic               tx_speed_sel, ext_loop, ra;
	logic [1:0]         ref_ratio_sel, s;
	logic [9:0]         tx_data, rx_word, word;
	logic [9:0]         kw [2];
	spa_pkg::spa_pair_t rx_in, ser_out;
	int                 miscompares = 0;
	int                 n_compared = 0;
	int                 cycles = 0;
	int                 i;
	spa_proto_model spa_proto_model_inst (.clk_sys(clk_sys), .rst(rst),
		.word(word), .tx_byte_clk(tx_byte_clk), .ref_clk_a(ref_clk_a),
		.tx_data(tx_data));
	spa_align_ctrl spa_align_ctrl_inst (.clk_sys(clk_sys), .rst(rst),
		.ce(1'b1), .tx_byte_clk(tx_byte_clk), .tx_data(tx_data),
		.tx_speed_sel(tx_speed_sel), .ref_clk_a(ref_clk_a),
		.ref_ratio_sel(ref_ratio_sel),
		.loopback_en(loopback_en), .rx_in(rx_in), .rx_speed_sel(1'b1),
		.align_en(align_en), .ser_out(ser_out), .rx_word(rx_word),
		.rec_clk_a(rec_clk_a), .rec_clk_b(rec_clk_b),
		.comma_found(comma_found), .rx_signal_lost(rx_signal_lost));
	task automatic give_verdict();
		$display("compared %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Bounded wait on a level, counted as a mismatch when it never comes
	task automatic wait_for(input bit loss, input int lim);
		int n;
		n = 0;
		while ((loss ? rx_signal_lost : comma_found) !== 1'b1 && n < lim) begin
			@(negedge clk_sys);
			n++;
		end
		`SPA_CHK(loss ? rx_signal_lost : comma_found, 1'b1)
	endtask
	// Far end of the line: quiet, or our own output wired back outside
	always @(negedge clk_sys) begin
		if (ext_loop)
			rx_in <= ser_out;
		else
			rx_in <= '{p: 1'b0, n: 1'b0};
	end
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 8000) begin
			miscompares++;
			give_verdict();
		end
	end
	initial begin
		rst = 1'b1;
		loopback_en = 1'b0;
		align_en = 1'b1;
		ext_loop = 1'b0;
		tx_speed_sel = 1'b1;
		ref_ratio_sel = 2'h0;
		word = `SPA_K285_NEG;
		kw[0] = `SPA_K285_NEG;
		kw[1] = `SPA_K285_POS;
		repeat (2) @(negedge clk_sys);
		`SPA_CHK(ser_out, `SPA_SER_IDLE)
		`SPA_CHK({rec_clk_a, rec_clk_b}, 2'h2)
		`SPA_CHK({comma_found, rx_signal_lost}, 2'h1)
		rst = 1'b0;
		$display("reset test done");
		loopback_en = 1'b1;
		// Outside line held quiet, so only the internal path can align
		for (i = 0; i < 2; i++) begin
			word = kw[i];
			// Long enough for the previous comma to drain from the pipe
			repeat (50) @(negedge clk_sys);
			`SPA_CHK(ser_out, `SPA_SER_IDLE)
			wait_for(1'b0, 300);
			`SPA_CHK(rx_word, kw[i])
			`SPA_CHK({rec_clk_a, rec_clk_b}, 2'h1)
			// Loss lags the first comma by one edge
			@(negedge clk_sys);
			`SPA_CHK(rx_signal_lost, 1'b0)
		end
		$display("loopback comma test done");
		loopback_en = 1'b0;
		ext_loop = 1'b1;
		repeat (50) @(negedge clk_sys);
		wait_for(1'b0, 300);
		`SPA_CHK(rx_word, kw[1])
		`SPA_CHK({rec_clk_a, rec_clk_b}, 2'h1)
		@(negedge clk_sys);
		`SPA_CHK(rx_signal_lost, 1'b0)
		$display("external loop test done");
		align_en = 1'b0;
		repeat (2) @(negedge clk_sys);
		for (i = 0; i < 200; i++) begin
			@(negedge clk_sys);
			`SPA_CHK(comma_found, 1'b0)
		end
		$display("align disable test done");
		tx_speed_sel = 1'b0;
		repeat (4) @(negedge clk_sys);
		s = {ser_out.p, ser_out.p};
		for (i = 0; i < 40; i++) begin
			@(negedge clk_sys);
			// Filler toggles every bit, so full speed would change twice
			`SPA_CHK((ser_out.p != s[0]) && (s[0] != s[1]), 1'b0)
			s = {s[0], ser_out.p};
		end
		tx_speed_sel = 1'b1;
		$display("half speed test done");
		ext_loop = 1'b0;
		wait_for(1'b1, 3000);
		`SPA_CHK(rec_clk_a, ~rec_clk_b)
		`SPA_CHK(ser_out.n, ~ser_out.p)
		ra = rec_clk_a;
		repeat (10) @(negedge clk_sys);
		`SPA_CHK(rec_clk_a, ~ra)
		for (i = 1; i < 3; i++) begin
			ref_ratio_sel = i[1:0];
			ra = rec_clk_a;
			repeat (5) @(negedge clk_sys);
			`SPA_CHK(rec_clk_a, ~ra)
		end
		$display("signal loss test done");
		give_verdict();
	end
endmodule
`default_nettype wire
